// >>> hw/sfr_pkg.sv
// Package for the fault-report and alert slave of the dual socket power switch
// Assumes a 50 MHz system clock that oversamples the serial bus pins
package sfr_pkg;
    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    localparam logic [6:0] SFR_ADDR_PTR   = 7'h0C;
    localparam logic [6:0] SFR_ADDR_A_LOW = 7'h50;
    localparam logic [6:0] SFR_ADDR_A_HI  = 7'h52;
    // ------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------
    localparam int         SFR_BIT_CAT    = 7;
    localparam int         SFR_BIT_F_LO   = 3;
    localparam int         SFR_BIT_CHAN   = 2;
    localparam logic       SFR_CHAN_DUAL  = 1'b0;
    localparam logic [3:0] SFR_FAULT_RST  = 4'h0;
    localparam logic       SFR_CAT_RST    = 1'b0;
    localparam logic       SFR_MASK_RST   = 1'b0;
    localparam logic [3:0] SFR_BITCNT_RST = 4'h0;
    localparam logic [7:0] SFR_SHIFT_RST  = 8'h00;

    // Fault monitor inputs
    typedef struct packed {
        logic thermal;
        logic uvlo;
        logic [3:0] over_current; // [3] socket A supply .. [0] socket B program
    } sfr_fault_type;

    typedef enum logic [2:0] {
        SFR_IDLE   = 3'b000,
        SFR_ADDR   = 3'b001,
        SFR_ACK    = 3'b010,
        SFR_TX     = 3'b011,
        SFR_MACK   = 3'b100,
        SFR_WRDATA = 3'b101,
        SFR_WRACK  = 3'b110,
        SFR_WAIT   = 3'b111
    } sfr_state_type;
endpackage

// >>> hw/sfr_smbus_fault.sv
// Serial-bus slave that reports latched faults and drives the alert line
// Assumes bus pins arrive asynchronously; open-drain pads resolved outside
// Contract
// R1 - Status bit 7 latches thermal or undervoltage catastrophic fault
// R2 - Bits 6..3 latch socket A supply, A program, B supply, B program faults
// R3 - Bit 2 unlatched, reads 0 for this dual-channel device
// R4 - Bits 1 and 0 reserved, unlatched, read zero
// R5 - Valid read address acknowledged; device then transmits synced to master clock
// R6 - Master ends each read by not acknowledging the byte
// R7 - Repeated start after a write is accepted, ready for read
// R8 - Device is slave only; its sole self-initiated action is pulling alert low
// R9 - Alert raised only for overcurrent, undervoltage lockout or thermal faults
// R10 - Power-on reset clears all registers; contents held while logic supply stays up
// R11 - Any fault asserts alert at once and latches it with pointer data
// R12 - Pointer-address read releases alert and returns own address
// R13 - Persisting fault reasserts alert after pointer read, latches not reloaded
// R14 - Spurious alert at power-up cleared by a pointer-address read
// R15 - Status read shifts byte out, then clears latches; present faults relatch
// R16 - Alerting device sends own address in first byte of pointer read
// R17 - Bit arbitration, lowest address wins; loser does not ack, keeps alert
// R18 - Host alert input is level sensitive
// R19 - Master changes data only after clock falling edge
// R20 - Reads answered only at channel-A address per select pin, or pointer address
// R21 - Pointer address recognised for every address-select setting
// R22 - Mask bit from channel-A command suppresses fault alerts; code ignores the written command and takes the mask from the alert_mask_i pin
// R23 - Bytes sent MSB first; after not-acknowledge release data, await stop/start
`timescale 1ns/100ps
module sfr_smbus_fault
    import sfr_pkg::*;
(
    // Clock and power-on reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // Serial bus pins
    input  wire logic          bus_clk_i,
    input  wire logic          bus_data_i,
    output logic               bus_data_o,
    output logic               bus_data_oe_o,
    // Alert open-drain pin
    output logic               alert_o,
    output logic               alert_oe_o,
    // Strap and settings
    input  wire logic          addr_select_i,
    input  wire logic          alert_mask_i,
    // Analog monitors
    input  sfr_pkg::sfr_fault_type fault_i,
    // Status view
    output logic [7:0]         fault_status_o
);
    import sfr_pkg::*;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q, sel_s_q, msk_s_q;
    logic [7:0] flt_s1_q, flt_s2_q;
    logic       scl_d1_q, sda_d1_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_s_q  <= 2'h3;
            sda_s_q  <= 2'h3;
            sel_s_q  <= 2'h0;
            msk_s_q  <= 2'h0;
            flt_s1_q <= 8'h00;
            flt_s2_q <= 8'h00;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_s_q  <= {scl_s_q[0], bus_clk_i};
            sda_s_q  <= {sda_s_q[0], bus_data_i};
            sel_s_q  <= {sel_s_q[0], addr_select_i};
            msk_s_q  <= {msk_s_q[0], alert_mask_i};
            flt_s1_q <= {2'h0, fault_i};
            flt_s2_q <= flt_s1_q;
            scl_d1_q <= scl_s_q[1];
            sda_d1_q <= sda_s_q[1];
        end
    end

    logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
    assign scl      = scl_s_q[1];
    assign sda      = sda_s_q[1];
    assign scl_rise = scl & ~scl_d1_q;
    assign scl_fall = ~scl & scl_d1_q;
    assign start_ev = scl & scl_d1_q & sda_d1_q & ~sda; // R19
    assign stop_ev  = scl & scl_d1_q & ~sda_d1_q & sda;

    sfr_fault_type flt;
    logic          cat_now;
    logic [3:0]    oc_now;
    logic          any_fault;
    logic [6:0]    own_addr;
    assign flt       = sfr_fault_type'(flt_s2_q[5:0]);
    assign cat_now   = flt.thermal | flt.uvlo;
    assign oc_now    = flt.over_current | {4{flt.uvlo}};
    assign any_fault = cat_now | (|flt.over_current); // R9
    assign own_addr  = sel_s_q[1] ? SFR_ADDR_A_HI : SFR_ADDR_A_LOW; // R20

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    sfr_state_type st_q;
    logic [3:0]    cnt_q;
    logic [7:0]    sh_q;
    logic          rd_ptr_q;
    logic          lost_q;
    logic          status_done, ptr_done;
    logic          addr_ptr, addr_own, alert_q;
    logic [7:0]    status_byte;
    assign addr_ptr = sh_q[7:1] == SFR_ADDR_PTR; // R21
    assign addr_own = sh_q[7:1] == own_addr;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q     <= SFR_IDLE;
            cnt_q    <= SFR_BITCNT_RST;
            sh_q     <= SFR_SHIFT_RST;
            rd_ptr_q <= 1'b0;
            lost_q   <= 1'b0;
        end else if (start_ev) begin
            st_q  <= SFR_ADDR; // R7
            cnt_q <= SFR_BITCNT_RST;
        end else if (stop_ev) begin
            st_q <= SFR_IDLE;
        end else begin
            case (st_q)
                SFR_ADDR: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        if (sh_q[0] && (addr_own || (addr_ptr && alert_q))) begin // R5 R20 R16
                            st_q     <= SFR_ACK;
                            rd_ptr_q <= addr_ptr;
                        end else if (!sh_q[0] && addr_own) begin
                            st_q <= SFR_WRDATA;
                        end else begin
                            st_q <= SFR_WAIT;
                        end
                        cnt_q <= SFR_BITCNT_RST;
                    end
                end
                SFR_ACK: begin
                    if (scl_fall) begin
                        st_q   <= SFR_TX;
                        sh_q   <= rd_ptr_q ? {own_addr, 1'b1} : status_byte;
                        lost_q <= 1'b0;
                    end
                end
                SFR_TX: begin
                    if (scl_rise && rd_ptr_q && sh_q[7] && !sda) begin
                        lost_q <= 1'b1; // R17
                    end
                    if (scl_fall) begin
                        sh_q  <= {sh_q[6:0], 1'b1}; // R23
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            st_q <= SFR_MACK;
                        end
                    end
                end
                SFR_MACK: begin
                    if (scl_fall) begin
                        st_q <= SFR_WAIT; // R6 R23
                    end
                end
                SFR_WRDATA: begin
                    if (scl_fall) begin
                        st_q  <= SFR_WRACK;
                        cnt_q <= SFR_BITCNT_RST;
                    end
                end
                SFR_WRACK: begin
                    if (scl_rise && cnt_q < 4'h8) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        cnt_q <= 4'h9;
                    end else if (scl_fall && cnt_q == 4'h9) begin
                        st_q <= SFR_WAIT; // R7
                    end
                end
                default: ;
            endcase
        end
    end

    // Completion of a read, seen at the master's ack slot
    assign status_done = st_q == SFR_MACK && scl_fall && !rd_ptr_q;
    assign ptr_done    = st_q == SFR_MACK && scl_fall && rd_ptr_q && !lost_q;

    // ------------------------------------------------------------
    // Fault latches and alert
    // ------------------------------------------------------------
    logic       cat_q;
    logic [3:0] oc_q;
    logic       armed;
    assign armed = ~msk_s_q[1] & any_fault; // R22
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cat_q <= SFR_CAT_RST; // R10
            oc_q  <= SFR_FAULT_RST;
        end else if (status_done) begin
            cat_q <= cat_now; // R15
            oc_q  <= oc_now;
        end else if (!alert_q) begin
            cat_q <= cat_q | cat_now; // R1 R2 R13
            oc_q  <= oc_q | oc_now;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alert_q <= 1'b0;
        end else if (armed) begin
            alert_q <= 1'b1; // R11 R13 R8
        end else if (ptr_done) begin
            alert_q <= 1'b0; // R12 R14
        end
    end

    assign status_byte = {cat_q, oc_q, SFR_CHAN_DUAL, 2'b00}; // R3 R4

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic drv_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= (st_q == SFR_ACK) || (st_q == SFR_WRDATA) || (st_q == SFR_WRACK && cnt_q == 4'h9)
                  || (st_q == SFR_TX && !sh_q[7] && !lost_q);
        end
    end
    assign bus_data_o     = 1'b0;
    assign bus_data_oe_o  = drv_q;
    assign alert_o        = 1'b0;
    assign alert_oe_o     = alert_q;
    assign fault_status_o = status_byte;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cat_bit;
        @(posedge clk_i) disable iff (!rst_n_i) cat_now && !alert_q |=> fault_status_o[7];
    endproperty
    a_cat_bit: assert property (p_cat_bit) else $error("cat bit"); // R1
    property p_fault_bits;
        @(posedge clk_i) disable iff (!rst_n_i) !alert_q |=> (fault_status_o[6:3] & $past(oc_now)) == $past(oc_now);
    endproperty
    a_fault_bits: assert property (p_fault_bits) else $error("fault bits"); // R2
    property p_low_bits;
        @(posedge clk_i) disable iff (!rst_n_i) fault_status_o[2:0] == 3'h0;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low bits"); // R3 R4
    property p_alert_set;
        @(posedge clk_i) disable iff (!rst_n_i) armed |=> alert_oe_o;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert not set"); // R11
    property p_alert_cause;
        @(posedge clk_i) disable iff (!rst_n_i) $rose(alert_q) |-> $past(armed);
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert no cause"); // R9
    property p_alert_clr;
        @(posedge clk_i) disable iff (!rst_n_i) ptr_done && !armed |=> !alert_q;
    endproperty
    a_alert_clr: assert property (p_alert_clr) else $error("alert not cleared"); // R12
    property p_status_clr;
        @(posedge clk_i) disable iff (!rst_n_i) status_done |=> oc_q == $past(oc_now);
    endproperty
    a_status_clr: assert property (p_status_clr) else $error("latch not reloaded"); // R15
    property p_release;
        @(posedge clk_i) disable iff (!rst_n_i) st_q == SFR_WAIT ##1 st_q == SFR_WAIT |-> !bus_data_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("data held"); // R23
    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i) alert_q && !status_done |=> oc_q == $past(oc_q);
    endproperty
    a_hold: assert property (p_hold) else $error("latch reloaded"); // R13
    property p_ack_drive;
        @(posedge clk_i) disable iff (!rst_n_i)
            (st_q == SFR_ACK || st_q == SFR_WRDATA) ##1 (st_q == SFR_ACK || st_q == SFR_WRDATA) |-> bus_data_oe_o;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("address not acknowledged"); // R5 R7
    property p_mask;
        @(posedge clk_i) disable iff (!rst_n_i) msk_s_q[1] && !alert_q |=> !alert_q;
    endproperty
    a_mask: assert property (p_mask) else $error("masked fault raised alert"); // R22
    property p_tx_msb;
        @(posedge clk_i) disable iff (!rst_n_i)
            (st_q == SFR_TX && !lost_q) ##1 st_q == SFR_TX |-> bus_data_oe_o == !$past(sh_q[7]);
    endproperty
    a_tx_msb: assert property (p_tx_msb) else $error("data bit order"); // R23
    c_ptr: cover property (@(posedge clk_i) ptr_done);
    c_status: cover property (@(posedge clk_i) status_done);
    c_lost: cover property (@(posedge clk_i) lost_q && st_q == SFR_MACK);
    c_write: cover property (@(posedge clk_i) st_q == SFR_WRACK && scl_fall && cnt_q == 4'h9);
    c_relatch: cover property (@(posedge clk_i) status_done && any_fault);
endmodule

// >>> verif/sfr_tb_master.sv
// Bus master model: start, stop and byte transfers on a 160 ns bus clock
// Assumes the bench resolves the pulled-up data line and returns it here
`timescale 1ns/100ps
module sfr_tb_master (
    // Pacing clock
    input  wire logic clk_i,
    // Resolved data line
    input  wire logic bus_data_i,
    // Driven pins
    output logic      bus_clk_o,
    output logic      data_low_o
);
    initial begin
        bus_clk_o  = 1'b1;
        data_low_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Start or repeated start; clock stands high between frames
    task automatic start();
        wait_clk(2);
        data_low_o <= 1'b0;
        wait_clk(2);
        bus_clk_o  <= 1'b1;
        wait_clk(4);
        data_low_o <= 1'b1;
        wait_clk(4);
        bus_clk_o  <= 1'b0;
    endtask

    task automatic stop();
        wait_clk(2);
        data_low_o <= 1'b1;
        wait_clk(2);
        bus_clk_o  <= 1'b1;
        wait_clk(4);
        data_low_o <= 1'b0;
        wait_clk(4);
    endtask

    // Data changes only while the bus clock is low
    task automatic xbit(input logic tx, output logic rx);
        wait_clk(2);
        data_low_o <= ~tx;
        wait_clk(2);
        bus_clk_o  <= 1'b1;
        wait_clk(4);
        rx = bus_data_i;
        bus_clk_o  <= 1'b0;
    endtask

    task automatic xbyte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            xbit(tx[i], rx[i]);
        end
        xbit(mack, ack);
    endtask

    // Other byte models a rival slave pulling the line during the data phase
    task automatic read(input logic [6:0] addr, input logic [7:0] other, output logic ack, output logic [7:0] data);
        logic [7:0] rx;
        logic       nack;
        start();
        xbyte({addr, 1'b1}, 1'b1, rx, ack);
        data = 8'h00;
        if (ack === 1'b0) begin
            xbyte(other, 1'b1, data, nack);
        end
        stop();
    endtask

    // Write left open so a repeated start follows
    task automatic write_open(input logic [6:0] addr, input logic [7:0] cmd, output logic ack_a, output logic ack_d);
        logic [7:0] rx;
        start();
        xbyte({addr, 1'b0}, 1'b1, rx, ack_a);
        xbyte(cmd, 1'b1, rx, ack_d);
    endtask
endmodule

// >>> verif/test_sfr_smbus_fault.sv
// Self-checking bench for the fault-report and alert slave
// Assumes the master model in sfr_tb_master and a pulled-up data line
`timescale 1ns/100ps
module test_sfr_smbus_fault;
    import sfr_pkg::*;
    logic          clk_i;
    logic          rst_n_i;
    logic          addr_select_i;
    logic          alert_mask_i;
    sfr_fault_type fault_i;
    logic          bus_clk;
    logic          data_low;
    logic          bus_data_o;
    logic          bus_data_oe_o;
    logic          alert_o;
    logic          alert_oe_o;
    logic [7:0]    fault_status_o;
    wire           bus_data = (bus_data_oe_o ? bus_data_o : 1'b1) & ~data_low;
    wire           alert_line = alert_oe_o ? alert_o : 1'b1;
    int            n_errors;
    int            samples_checked;
    logic          ack;
    logic          ack_d;
    logic [7:0]    data;

    sfr_smbus_fault i_sfr_smbus_fault (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_clk_i(bus_clk), .bus_data_i(bus_data),
        .bus_data_o(bus_data_o), .bus_data_oe_o(bus_data_oe_o), .alert_o(alert_o),
        .alert_oe_o(alert_oe_o), .addr_select_i(addr_select_i), .alert_mask_i(alert_mask_i),
        .fault_i(fault_i), .fault_status_o(fault_status_o));
    sfr_tb_master i_sfr_tb_master (.clk_i(clk_i), .bus_data_i(bus_data), .bus_clk_o(bus_clk), .data_low_o(data_low));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic al(input logic v);
        check("alert line", {7'h00, ~v}, {7'h00, alert_line});
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] oth, input logic eack, input logic [7:0] ed,
                      input logic [7:0] msk);
        i_sfr_tb_master.read(a, oth, ack, data);
        check("address ack", {7'h00, eack}, {7'h00, ack});
        if (eack === 1'b0) begin
            check("read byte", ed & msk, data & msk);
        end
    endtask

    task automatic pulse(input logic [5:0] f);
        @(posedge clk_i);
        fault_i <= sfr_fault_type'(f);
        repeat (6) @(posedge clk_i);
        fault_i <= '0;
        repeat (6) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("status in reset", 8'h00, fault_status_o);
        al(1'b0);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(SFR_ADDR_PTR, 8'hFF, 1'b1, 8'h00, 8'hFF);
        al(1'b0);
    endtask

    // Thermal, undervoltage, then each overcurrent in turn
    task automatic t_latch();
        for (int k = 0; k < 6; k++) begin
            pulse(6'h20 >> k);
            al(1'b1);
            rd(SFR_ADDR_PTR, 8'hFF, 1'b0, {SFR_ADDR_A_LOW, 1'b1}, 8'hFF);
            al(1'b0);
            rd(SFR_ADDR_A_LOW, 8'hFF, 1'b0,
               (k == 0) ? 8'h80 : (k == 1) ? 8'hF8 : (8'h40 >> (k - 2)), 8'hFF);
            rd(SFR_ADDR_A_LOW, 8'hFF, 1'b0, 8'h00, 8'hFF);
        end
    endtask

    task automatic t_mask();
        alert_mask_i <= 1'b1;
        pulse(6'h04);
        al(1'b0);
        alert_mask_i <= 1'b0;
        i_sfr_tb_master.read(SFR_ADDR_A_LOW, 8'hFF, ack, data);
    endtask

    task automatic t_restart();
        i_sfr_tb_master.write_open(SFR_ADDR_A_LOW, 8'h00, ack, ack_d);
        check("write acks", 8'h00, {6'h00, ack, ack_d});
        rd(SFR_ADDR_A_LOW, 8'hFF, 1'b0, 8'h00, 8'hFF);
        rd(SFR_ADDR_A_HI, 8'hFF, 1'b1, 8'h00, 8'hFF);
        rd(SFR_ADDR_PTR, 8'hFF, 1'b1, 8'h00, 8'hFF);
    endtask

    task automatic t_persist();
        fault_i <= sfr_fault_type'(6'h01);
        repeat (8) @(posedge clk_i);
        rd(SFR_ADDR_PTR, 8'hFF, 1'b0, {SFR_ADDR_A_LOW, 1'b1}, 8'hFF);
        repeat (8) @(posedge clk_i);
        al(1'b1);
        fault_i <= sfr_fault_type'(6'h09);
        repeat (8) @(posedge clk_i);
        rd(SFR_ADDR_A_LOW, 8'hFF, 1'b0, 8'h08, 8'hFF);
        check("status relatched", 8'h48, fault_status_o);
        fault_i <= '0;
        repeat (8) @(posedge clk_i);
        rd(SFR_ADDR_PTR, 8'hFF, 1'b0, {SFR_ADDR_A_LOW, 1'b1}, 8'hFF);
        rd(SFR_ADDR_A_LOW, 8'hFF, 1'b0, 8'h48, 8'hFF);
        rd(SFR_ADDR_A_LOW, 8'hFF, 1'b0, 8'h00, 8'hFF);
    endtask

    task automatic t_select_arb();
        addr_select_i <= 1'b1;
        pulse(6'h02);
        rd(SFR_ADDR_PTR, 8'h21, 1'b0, 8'h21, 8'hFF);
        al(1'b1);
        rd(SFR_ADDR_PTR, 8'hFF, 1'b0, {SFR_ADDR_A_HI, 1'b1}, 8'hFF);
        rd(SFR_ADDR_A_HI, 8'hFF, 1'b0, 8'h10, 8'hFF);
        rd(SFR_ADDR_A_LOW, 8'hFF, 1'b1, 8'h00, 8'hFF);
    endtask

    // Power-on reset in mid-run clears latches and alert
    task automatic t_por();
        pulse(6'h10);
        check("status before reset", 8'hF8, fault_status_o);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("status in reset", 8'h00, fault_status_o);
        al(1'b0);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(SFR_ADDR_A_HI, 8'hFF, 1'b0, 8'h00, 8'hFF);
    endtask

    // ------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        n_errors        = 0;
        samples_checked = 0;
        rst_n_i         = 1'b0;
        addr_select_i   = 1'b0;
        alert_mask_i    = 1'b0;
        fault_i         = '0;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_latch();
        t_mask();
        t_restart();
        t_persist();
        t_select_arb();
        t_por();
        final_report();
    end

    initial begin
        #600000;
        n_errors++;
        final_report();
    end
endmodule
